// *** design/autobaud_params.svh ***
`ifndef AUTOBAUD_PARAMS_SVH
`define AUTOBAUD_PARAMS_SVH

// System clock rate in hertz and the sync character the sender must use.
`define AUTOBAUD_FOSC_HZ        10000000
`define AUTOBAUD_SYNC_CHAR      8'h55

// Counter clock dividers while measuring, eight times the base divider.
`define AUTOBAUD_DIV_SLOW       10'h200
`define AUTOBAUD_DIV_MID        10'h080
`define AUTOBAUD_DIV_FAST       10'h020

// Measurement constants: start value, top of count, rising edge count.
`define AUTOBAUD_COUNT_START    16'h0001
`define AUTOBAUD_COUNT_MAX      16'hFFFF
`define AUTOBAUD_LAST_EDGE      3'h4

// Sender register offsets on the AXI4-Lite slave.
`define SENDER_CTRL_OFS         4'h0
`define SENDER_DATA_OFS         4'h4
`define SENDER_BITCYC_OFS       4'h8

// Sender control bits and reset values.
`define SENDER_GO_BIT           0
`define SENDER_BREAK_BIT        1
`define SENDER_DATA_RST         8'h55
`define SENDER_BITCYC_RST       16'h0010

// Break is a start bit plus twelve zeros, then one stop bit.
`define SENDER_BREAK_LOW_BITS   13
`define SENDER_BREAK_BITS       4'hE
`define SENDER_FRAME_BITS       4'hA

// AXI response codes.
`define AXI_RESP_OKAY           2'h0
`define AXI_RESP_SLVERR         2'h2

`endif

// *** design/autobaud_pkg.sv ***
package autobaud_pkg;

  // Measurement sequencer of the detecting end.
  typedef enum logic [2:0] {
    ST_OFF,
    ST_WAIT_START,
    ST_BREAK_LOW,
    ST_WAIT_FIRST_RISE,
    ST_MEASURE
  } measure_state_t;

  // Character sender of the far end.
  typedef enum logic [1:0] {
    TX_IDLE,
    TX_BREAK,
    TX_FRAME
  } sender_state_t;

endpackage

// *** design/serial_line_if.sv ***
`timescale 1ns/1ps

// One serial line from the far sender to the detecting receiver.
interface serial_line_if;
  logic rx_line;

  modport device  (input  rx_line);
  modport partner (output rx_line);
endinterface

// *** design/tick_divider.sv ***
`timescale 1ns/1ps

// Emits one-cycle ticks every PERIOD cycles; restart realigns the phase.
module tick_divider #(
  parameter int W = 16
) (
  input  wire logic         clk,
  input  wire logic         rst,
  input  wire logic         restart,
  input  wire logic [W-1:0] period,
  output logic              tick
);

  logic [W-1:0] cnt_q;
  logic [W-1:0] cnt_d;
  logic [W-1:0] last;

  // A zero period is treated as one, so the tick never stops.
  assign last  = (period == '0) ? '0 : period - 1'b1;
  assign tick  = ~restart & (cnt_q == last);
  assign cnt_d = (restart | tick) ? '0 : cnt_q + 1'b1;

  // Phase counter.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt_q <= '0;
    end else begin
      cnt_q <= cnt_d;
    end
  end

endmodule // tick_divider

// *** design/autobaud_device.sv ***
// Implementation choices: the register addresses and register access over AXI4-Lite.
`timescale 1ns/1ps
`include "autobaud_params.svh"
// Overview of operation
// - Receive edges time the counter, not sampling.
// - Measure sync 55h across its five edges.
// - Enable starts calibration; receiver held idle.
// - Counting starts at first rise after start.
// - Fifth rise: keep count, clear enable, flag.
// - Reading receive data clears the flag.
// - Both divisor bytes form one 16-bit counter.
// - Counter runs at one eighth base clock.
// - Width and speed bits pick 512/128/32.
// - Count starts at one; software subtracts one.
// - With wake enable, measure byte after break.
// - Counter wrap before fifth rise sets overflow.
// - After overflow keep counting, finish normally.
// - Overflow cleared only by direct write.
// - Overflow clear ignored while enable still set.
// - Software checks high byte zero in 8-bit mode.
// - Software keeps baud within measurable range.

module autobaud_device
  import autobaud_pkg::*;
(
  input  wire logic        CLOCK,
  input  wire logic        RST,
  serial_line_if.device    LINE,
  input  wire logic        AUTOBAUD_START,
  input  wire logic        AUTOBAUD_STOP,
  input  wire logic        WAKE_SET,
  input  wire logic        OVERFLOW_CLEAR,
  input  wire logic        RECEIVE_DATA_READ,
  input  wire logic        DIVISOR_WRITE,
  input  wire logic [15:0] DIVISOR_WDATA,
  input  wire logic        DIVISOR_16BIT_SELECT,
  input  wire logic        HIGH_SPEED_SELECT,
  output logic             AUTOBAUD_ENABLE,
  output logic             WAKE_ON_BREAK_ENABLE,
  output logic             AUTOBAUD_OVERFLOW_FLAG,
  output logic             RECEIVE_IRQ_FLAG,
  output logic             RECEIVER_HOLD,
  output logic [7:0]       DIVISOR_HIGH_BYTE,
  output logic [7:0]       DIVISOR_LOW_BYTE
);

  logic           sync1_q;
  logic           sync2_q;
  logic           line_prev_q;
  logic           rise;
  logic           fall;

  measure_state_t state_q;
  measure_state_t state_d;
  logic           enable_q;
  logic           enable_d;
  logic           wake_q;
  logic           wake_d;
  logic           ovf_q;
  logic           ovf_d;
  logic           irq_q;
  logic           irq_d;
  logic           hold_q;
  logic [15:0]    count_q;
  logic [15:0]    count_d;
  logic [2:0]     edges_q;
  logic [2:0]     edges_d;

  logic           first_rise;
  logic           break_end;
  logic           done;
  logic           wrap;
  logic           measuring;
  logic           ovf_clear_ok;
  logic           prescale_tick;
  logic [9:0]     prescale_period;

  // The first stage feeds only the second; edges come from the second.
  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      sync1_q     <= 1'b1;
      sync2_q     <= 1'b1;
      line_prev_q <= 1'b1;
    end else begin
      sync1_q     <= LINE.rx_line;
      sync2_q     <= sync1_q;
      line_prev_q <= sync2_q;
    end
  end

  // One-cycle edge pulses on the synchronised line.
  assign rise = sync2_q & ~line_prev_q;
  assign fall = ~sync2_q & line_prev_q;

  // Counter clock is one eighth of the normal base divider.
  assign prescale_period =
    ({DIVISOR_16BIT_SELECT, HIGH_SPEED_SELECT} == 2'b00) ?
      `AUTOBAUD_DIV_SLOW :
    ({DIVISOR_16BIT_SELECT, HIGH_SPEED_SELECT} == 2'b11) ?
      `AUTOBAUD_DIV_FAST : `AUTOBAUD_DIV_MID;

  // Prescaler restarts on the first rise so each edge times a full tick.
  tick_divider #(
    .W (10)
  ) u_prescale (
    .clk     (CLOCK),
    .rst     (RST),
    .restart (first_rise),
    .period  (prescale_period),
    .tick    (prescale_tick)
  );

  // Events of the measurement sequence; the state lingers one cycle after a
  // stop, so every event except break_end is gated by enable to keep an abort from finishing.
  assign measuring  = (state_q == ST_MEASURE) & enable_q;
  assign first_rise = (state_q == ST_WAIT_FIRST_RISE) & rise
                      & enable_q;
  assign break_end  = (state_q == ST_BREAK_LOW) & rise;
  assign done       = measuring & rise
                      & (edges_q == `AUTOBAUD_LAST_EDGE);
  assign wrap       = measuring & prescale_tick
                      & (count_q == `AUTOBAUD_COUNT_MAX);
  assign ovf_clear_ok = OVERFLOW_CLEAR & ~enable_q;

  // Sequencer: edges of the line, not a bit clock, drive each step after ST_OFF, which is left on enable.
  always_comb begin
    state_d = state_q;
    unique case (state_q)
      ST_OFF: begin
        if (enable_q) begin
          state_d = ST_WAIT_START;
        end
      end
      ST_WAIT_START: begin
        if (fall) begin
          state_d = wake_q ? ST_BREAK_LOW : ST_WAIT_FIRST_RISE;
        end
      end
      ST_BREAK_LOW: begin
        if (rise) begin
          state_d = ST_WAIT_START;
        end
      end
      ST_WAIT_FIRST_RISE: begin
        if (rise) begin
          state_d = ST_MEASURE;
        end
      end
      ST_MEASURE: begin
        if (done) begin
          state_d = ST_OFF;
        end
      end
    endcase
    if (!enable_q) begin
      state_d = ST_OFF;
    end
  end

  // Counter: loaded with one at the first rise, then one per tick.
  always_comb begin
    count_d = count_q;
    edges_d = edges_q;
    if (first_rise) begin
      count_d = `AUTOBAUD_COUNT_START;
      edges_d = 3'h1;
    end else if (measuring) begin
      if (prescale_tick) begin
        count_d = count_q + 16'h0001;
      end
      if (rise) begin
        edges_d = edges_q + 3'h1;
      end
    end else if (DIVISOR_WRITE && !enable_q) begin
      count_d = DIVISOR_WDATA;
    end
  end

  // Control and status flags; hardware set wins over a same-cycle clear.
  assign enable_d = (enable_q | AUTOBAUD_START)
                    & ~AUTOBAUD_STOP & ~done;
  assign wake_d   = (wake_q & ~break_end) | WAKE_SET;
  assign ovf_d    = wrap | (ovf_q & ~ovf_clear_ok);
  assign irq_d    = done | (irq_q & ~RECEIVE_DATA_READ);

  // Sequencer and counter registers.
  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      state_q <= ST_OFF;
      count_q <= 16'h0000;
      edges_q <= 3'h0;
    end else begin
      state_q <= state_d;
      count_q <= count_d;
      edges_q <= edges_d;
    end
  end

  // Flag registers.
  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      enable_q <= 1'b0;
      wake_q   <= 1'b0;
      ovf_q    <= 1'b0;
      irq_q    <= 1'b0;
      hold_q   <= 1'b0;
    end else begin
      enable_q <= enable_d;
      wake_q   <= wake_d;
      ovf_q    <= ovf_d;
      irq_q    <= irq_d;
      hold_q   <= enable_d;
    end
  end

  // Outputs come straight from the registers above.
  assign AUTOBAUD_ENABLE        = enable_q;
  assign WAKE_ON_BREAK_ENABLE   = wake_q;
  assign AUTOBAUD_OVERFLOW_FLAG = ovf_q;
  assign RECEIVE_IRQ_FLAG       = irq_q;
  assign RECEIVER_HOLD          = hold_q;
  assign DIVISOR_HIGH_BYTE      = count_q[15:8];
  assign DIVISOR_LOW_BYTE       = count_q[7:0];

endmodule // autobaud_device

// *** design/sync_sender_host.sv ***
`timescale 1ns/1ps
`include "autobaud_params.svh"

// Far end: sends an optional break and then one character, over AXI4-Lite.
module sync_sender_host
  import autobaud_pkg::*;
(
  input  wire logic        CLOCK,
  input  wire logic        RST,
  serial_line_if.partner   LINE,
  input  wire logic [3:0]  AWADDR,
  input  wire logic        AWVALID,
  output logic             AWREADY,
  input  wire logic [31:0] WDATA,
  input  wire logic [3:0]  WSTRB,
  input  wire logic        WVALID,
  output logic             WREADY,
  output logic [1:0]       BRESP,
  output logic             BVALID,
  input  wire logic        BREADY,
  input  wire logic [3:0]  ARADDR,
  input  wire logic        ARVALID,
  output logic             ARREADY,
  output logic [31:0]      RDATA,
  output logic [1:0]       RRESP,
  output logic             RVALID,
  input  wire logic        RREADY
);

  logic          awready_q, wready_q, bvalid_q, arready_q, rvalid_q;
  logic          aw_got_q, w_got_q;
  logic [3:0]    awaddr_q;
  logic [31:0]   wdata_q;
  logic [1:0]    bresp_q, rresp_q;
  logic [31:0]   rdata_q;
  logic          aw_take, w_take, ar_take, have_aw, have_w, wr_do;
  logic [3:0]    wr_addr;
  logic [31:0]   wr_data;
  logic          aw_got_d, w_got_d, bvalid_d, rvalid_d;
  logic          wr_hit, rd_hit;
  logic [31:0]   rd_word;

  logic [7:0]    data_q;
  logic [15:0]   bitcyc_q;
  sender_state_t tx_q;
  logic [13:0]   shift_q;
  logic [3:0]    bits_q;
  logic          line_q;
  logic          go;
  logic          bit_tick;
  logic          last_bit;

  // Channel handshakes; a write runs once both address and data are held.
  assign aw_take  = AWVALID & awready_q;
  assign w_take   = WVALID & wready_q;
  assign ar_take  = ARVALID & arready_q;
  assign have_aw  = aw_got_q | aw_take;
  assign have_w   = w_got_q | w_take;
  assign wr_do    = have_aw & have_w & ~bvalid_q;
  assign wr_addr  = aw_take ? AWADDR : awaddr_q;
  assign wr_data  = w_take ? WDATA : wdata_q;
  assign aw_got_d = have_aw & ~wr_do;
  assign w_got_d  = have_w & ~wr_do;
  assign bvalid_d = wr_do | (bvalid_q & ~BREADY);
  assign rvalid_d = ar_take | (rvalid_q & ~RREADY);

  // Address decode for both directions.
  assign wr_hit = (wr_addr == `SENDER_CTRL_OFS)
                | (wr_addr == `SENDER_DATA_OFS)
                | (wr_addr == `SENDER_BITCYC_OFS);
  assign rd_hit = (ARADDR == `SENDER_CTRL_OFS)
                | (ARADDR == `SENDER_DATA_OFS)
                | (ARADDR == `SENDER_BITCYC_OFS);
  assign rd_word =
    (ARADDR == `SENDER_CTRL_OFS) ? {31'h0000_0000, tx_q != TX_IDLE} :
    (ARADDR == `SENDER_DATA_OFS) ? {24'h00_0000, data_q} :
    (ARADDR == `SENDER_BITCYC_OFS) ? {16'h0000, bitcyc_q} : 32'h0000_0000;

  // A start request while busy is ignored.
  assign go = wr_do & (wr_addr == `SENDER_CTRL_OFS) & WSTRB[0]
              & wr_data[`SENDER_GO_BIT] & (tx_q == TX_IDLE);

  // Bus slave registers.
  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      awready_q <= 1'b0;
      wready_q  <= 1'b0;
      arready_q <= 1'b0;
      bvalid_q  <= 1'b0;
      rvalid_q  <= 1'b0;
      aw_got_q  <= 1'b0;
      w_got_q   <= 1'b0;
      awaddr_q  <= 4'h0;
      wdata_q   <= 32'h0000_0000;
      bresp_q   <= `AXI_RESP_OKAY;
      rresp_q   <= `AXI_RESP_OKAY;
      rdata_q   <= 32'h0000_0000;
    end else begin
      awready_q <= ~aw_got_d & ~bvalid_d;
      wready_q  <= ~w_got_d & ~bvalid_d;
      arready_q <= ~rvalid_d;
      bvalid_q  <= bvalid_d;
      rvalid_q  <= rvalid_d;
      aw_got_q  <= aw_got_d;
      w_got_q   <= w_got_d;
      if (aw_take) begin
        awaddr_q <= AWADDR;
      end
      if (w_take) begin
        wdata_q <= WDATA;
      end
      if (wr_do) begin
        bresp_q <= wr_hit ? `AXI_RESP_OKAY : `AXI_RESP_SLVERR;
      end
      if (ar_take) begin
        rdata_q <= rd_word;
        rresp_q <= rd_hit ? `AXI_RESP_OKAY : `AXI_RESP_SLVERR;
      end
    end
  end

  // Character and bit-time registers, byte lanes honoured.
  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      data_q   <= `SENDER_DATA_RST;
      bitcyc_q <= `SENDER_BITCYC_RST;
    end else if (wr_do) begin
      if (wr_addr == `SENDER_DATA_OFS && WSTRB[0]) begin
        data_q <= wr_data[7:0];
      end
      if (wr_addr == `SENDER_BITCYC_OFS) begin
        if (WSTRB[0]) begin
          bitcyc_q[7:0] <= wr_data[7:0];
        end
        if (WSTRB[1]) begin
          bitcyc_q[15:8] <= wr_data[15:8];
        end
      end
    end
  end

  // Bit timer, realigned at the start of each transmission.
  tick_divider #(
    .W (16)
  ) u_bit_timer (
    .clk     (CLOCK),
    .rst     (RST),
    .restart (go),
    .period  (bitcyc_q),
    .tick    (bit_tick)
  );

  assign last_bit = bit_tick & (bits_q == 4'h1);

  // Sender: break of thirteen low bits and a stop, then start-data-stop.
  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      tx_q    <= TX_IDLE;
      shift_q <= 14'h3FFF;
      bits_q  <= 4'h0;
      line_q  <= 1'b1;
    end else if (go) begin
      if (wr_data[`SENDER_BREAK_BIT]) begin
        tx_q    <= TX_BREAK;
        shift_q <= {1'b1, {`SENDER_BREAK_LOW_BITS{1'b0}}};
        bits_q  <= `SENDER_BREAK_BITS;
      end else begin
        tx_q    <= TX_FRAME;
        shift_q <= {4'hF, 1'b1, data_q, 1'b0};
        bits_q  <= `SENDER_FRAME_BITS;
      end
      line_q <= 1'b0;
    end else if (last_bit && tx_q == TX_BREAK) begin
      tx_q    <= TX_FRAME;
      shift_q <= {4'hF, 1'b1, data_q, 1'b0};
      bits_q  <= `SENDER_FRAME_BITS;
      line_q  <= 1'b0;
    end else if (last_bit) begin
      tx_q    <= TX_IDLE;
      bits_q  <= 4'h0;
      line_q  <= 1'b1;
    end else if (bit_tick && tx_q != TX_IDLE) begin
      shift_q <= {1'b1, shift_q[13:1]};
      bits_q  <= bits_q - 4'h1;
      line_q  <= shift_q[1];
    end
  end

  // Outputs come straight from registers.
  assign LINE.rx_line = line_q;
  assign AWREADY      = awready_q;
  assign WREADY       = wready_q;
  assign BVALID       = bvalid_q;
  assign BRESP        = bresp_q;
  assign ARREADY      = arready_q;
  assign RVALID       = rvalid_q;
  assign RDATA        = rdata_q;
  assign RRESP        = rresp_q;

endmodule // sync_sender_host

// *** bench/autobaud_chk.sv ***
`timescale 1ns/1ps

// Watches the serial line and the detector's control and status pins.
module autobaud_chk (
  input wire logic       CLOCK,
  input wire logic       RST,
  input wire logic       rx_line,
  input wire logic       AUTOBAUD_START,
  input wire logic       AUTOBAUD_STOP,
  input wire logic       OVERFLOW_CLEAR,
  input wire logic       RECEIVE_DATA_READ,
  input wire logic       DIVISOR_WRITE,
  input wire logic       AUTOBAUD_ENABLE,
  input wire logic       WAKE_ON_BREAK_ENABLE,
  input wire logic       AUTOBAUD_OVERFLOW_FLAG,
  input wire logic       RECEIVE_IRQ_FLAG,
  input wire logic       RECEIVER_HOLD,
  input wire logic [7:0] DIVISOR_HIGH_BYTE,
  input wire logic [7:0] DIVISOR_LOW_BYTE
);
  // The divisor pair seen as one counter.
  wire [15:0] div = {DIVISOR_HIGH_BYTE, DIVISOR_LOW_BYTE};

  default clocking @(posedge CLOCK); endclocking
  default disable iff (RST);

  // Enable, hold and completion.
  a_start_sets_enable: assert property (
    AUTOBAUD_START && !AUTOBAUD_STOP |=> AUTOBAUD_ENABLE)
    else $error("enable not set by start");
  a_stop_clears_enable: assert property (
    AUTOBAUD_STOP |=> !AUTOBAUD_ENABLE)
    else $error("enable not cleared by stop");
  a_hold_while_cal: assert property (
    RECEIVER_HOLD == AUTOBAUD_ENABLE)
    else $error("receiver hold differs from enable");
  a_irq_on_done: assert property (
    $fell(AUTOBAUD_ENABLE) && !$past(AUTOBAUD_STOP) |-> RECEIVE_IRQ_FLAG)
    else $error("completion without irq");
  a_read_clears_irq: assert property (
    RECEIVE_DATA_READ && !AUTOBAUD_ENABLE |=> !RECEIVE_IRQ_FLAG)
    else $error("irq not cleared by read");

  // Divisor behaviour while idle and while counting.
  a_divisor_frozen_idle: assert property (
    !AUTOBAUD_ENABLE && !DIVISOR_WRITE |=> $stable(div))
    else $error("divisor moved while idle");
  a_count_steps_one: assert property (
    AUTOBAUD_ENABLE && $past(AUTOBAUD_ENABLE) && !$stable(div)
    |-> (div == $past(div) + 16'h0001) || (div == 16'h0001))
    else $error("counter step not one");

  // Overflow flag holding and wake clearing.
  a_ovf_kept_enabled: assert property (
    AUTOBAUD_OVERFLOW_FLAG && AUTOBAUD_ENABLE |=> AUTOBAUD_OVERFLOW_FLAG)
    else $error("overflow lost while enabled");
  a_ovf_needs_clear: assert property (
    AUTOBAUD_OVERFLOW_FLAG && !OVERFLOW_CLEAR |=> AUTOBAUD_OVERFLOW_FLAG)
    else $error("overflow lost without clear");
  a_wake_end_high: assert property (
    $fell(WAKE_ON_BREAK_ENABLE) |-> rx_line && $past(rx_line))
    else $error("wake cleared while line low");

  // Main scenarios reached.
  c_done: cover property ($fell(AUTOBAUD_ENABLE) && RECEIVE_IRQ_FLAG);
  c_read: cover property (RECEIVE_DATA_READ && RECEIVE_IRQ_FLAG);
  c_wake: cover property ($fell(WAKE_ON_BREAK_ENABLE));
endmodule // autobaud_chk

// *** bench/tb.sv ***
`timescale 1ns/1ps

module tb;
  logic        CLOCK = 1'b0;
  logic        RST = 1'b1;
  logic [5:0]  pl = '0;
  logic        sel16 = 1'b0;
  logic        hs = 1'b0;
  logic [15:0] dwd = '0;
  logic [3:0]  awaddr = '0;
  logic [3:0]  araddr = '0;
  logic [31:0] wdata = '0;
  logic        awvalid = 1'b0;
  logic        wvalid = 1'b0;
  logic        bready = 1'b0;
  logic        arvalid = 1'b0;
  logic        rready = 1'b0;
  wire         awready, wready, bvalid, arready, rvalid;
  wire [1:0]   bresp, rresp;
  wire [31:0]  rdata;
  wire         en, wk, ov, irq, hold;
  wire [7:0]   dh, dl;
  int          errors = 0;
  int          cmp_count = 0;
  logic [31:0] seed = 32'h0000_50B1;
  logic [31:0] d;
  logic [1:0]  r;
  logic [15:0] v;

  serial_line_if serial_line_if_i ();

  // Clock of 100 ns period.
  always #50 CLOCK = ~CLOCK;

  // Pulse bits: start, stop, wake, overflow clear, data read, divisor write.
  autobaud_device autobaud_device_i (
    .CLOCK(CLOCK), .RST(RST), .LINE(serial_line_if_i),
    .AUTOBAUD_START(pl[0]), .AUTOBAUD_STOP(pl[1]), .WAKE_SET(pl[2]),
    .OVERFLOW_CLEAR(pl[3]), .RECEIVE_DATA_READ(pl[4]),
    .DIVISOR_WRITE(pl[5]), .DIVISOR_WDATA(dwd),
    .DIVISOR_16BIT_SELECT(sel16), .HIGH_SPEED_SELECT(hs),
    .AUTOBAUD_ENABLE(en), .WAKE_ON_BREAK_ENABLE(wk),
    .AUTOBAUD_OVERFLOW_FLAG(ov), .RECEIVE_IRQ_FLAG(irq),
    .RECEIVER_HOLD(hold), .DIVISOR_HIGH_BYTE(dh), .DIVISOR_LOW_BYTE(dl));

  // Far sender, reached over AXI4-Lite.
  sync_sender_host sync_sender_host_i (
    .CLOCK(CLOCK), .RST(RST), .LINE(serial_line_if_i),
    .AWADDR(awaddr), .AWVALID(awvalid), .AWREADY(awready),
    .WDATA(wdata), .WSTRB(4'hF), .WVALID(wvalid), .WREADY(wready),
    .BRESP(bresp), .BVALID(bvalid), .BREADY(bready),
    .ARADDR(araddr), .ARVALID(arvalid), .ARREADY(arready),
    .RDATA(rdata), .RRESP(rresp), .RVALID(rvalid), .RREADY(rready));

  autobaud_chk autobaud_chk_i (
    .CLOCK(CLOCK), .RST(RST), .rx_line(serial_line_if_i.rx_line),
    .AUTOBAUD_START(pl[0]), .AUTOBAUD_STOP(pl[1]),
    .OVERFLOW_CLEAR(pl[3]), .RECEIVE_DATA_READ(pl[4]),
    .DIVISOR_WRITE(pl[5]), .AUTOBAUD_ENABLE(en),
    .WAKE_ON_BREAK_ENABLE(wk), .AUTOBAUD_OVERFLOW_FLAG(ov),
    .RECEIVE_IRQ_FLAG(irq), .RECEIVER_HOLD(hold),
    .DIVISOR_HIGH_BYTE(dh), .DIVISOR_LOW_BYTE(dl));

  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  // Reference model: the count starts at one and gains one per counter
  // clock period within the eight bit times between first and fifth rise.
  int exp_q[$];

  function automatic int model_div(int dv, int bt);
    return 1 + (8 * bt) / dv;
  endfunction

  task automatic chk(string n, logic [31:0] e, logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      errors++;
      $display("BAD %s exp %h got %h", n, e, g);
    end
  endtask

  task automatic summarize();
    $display("checks %0d mismatches %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  task automatic hang(string n);
    errors++;
    $display("BAD %s exp done got timeout", n);
    summarize();
  endtask

  // One control pulse, then a quiet edge so pulses never overlap.
  task automatic pulse(int b);
    pl[b] <= 1'b1;
    @(posedge CLOCK);
    pl <= '0;
    @(posedge CLOCK);
  endtask

  // Write: address and data offered together, each dropped when taken.
  task automatic axw(logic [3:0] a, logic [31:0] x, output logic [1:0] s);
    int n;
    awaddr <= a;
    wdata <= x;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (n = 0; n < 100; n++) begin
      @(posedge CLOCK);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid) break;
    end
    if (n == 100) hang("axi_write");
    s = bresp;
    bready <= 1'b0;
    @(posedge CLOCK);
  endtask

  task automatic axr(logic [3:0] a, output logic [31:0] x,
                     output logic [1:0] s);
    int n;
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (n = 0; n < 100; n++) begin
      @(posedge CLOCK);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid) break;
    end
    if (n == 100) hang("axi_read");
    x = rdata;
    s = rresp;
    rready <= 1'b0;
    @(posedge CLOCK);
  endtask

  // Measure one sync byte; expected count is one plus whole ticks in 8 bits.
  task automatic calib(logic [1:0] s, bit brk);
    int dv, k, b, n, e;
    dv = (s == 2'h0) ? 512 : (s == 2'h3) ? 32 : 128;
    k = 4 + int'(rnd() % 8);
    b = k * dv / 8 + dv / 16;
    exp_q.push_back(model_div(dv, b));
    sel16 <= s[1];
    hs <= s[0];
    axw(4'h8, b, r);
    if (brk) pulse(2);
    pulse(0);
    chk("enable", 32'h0000_0001, en);
    chk("hold", 32'h0000_0001, hold);
    axw(4'h0, brk ? 32'h0000_0003 : 32'h0000_0001, r);
    for (n = 0; n < 30000 && irq !== 1'b1; n++) @(posedge CLOCK);
    if (n == 30000) hang("irq_wait");
    e = exp_q.pop_front();
    chk("divisor", e, {dh, dl});
    chk("no_overflow", 32'h0000_0000, ov);
    if (!s[1]) chk("high_zero", 32'h0000_0000, dh);
    chk("en_hold_wake", 32'h0000_0000, {en, hold, wk});
    repeat (5) @(posedge CLOCK);
    chk("irq_held", 32'h0000_0001, irq);
    pulse(4);
    chk("irq_clear", 32'h0000_0000, irq);
    repeat (2 * b) @(posedge CLOCK);
    axr(4'h0, d, r);
    chk("busy", 32'h0000_0000, d[0]);
    $display("calibration sel %0d break %0d done", s, brk);
  endtask

  // Main sequence.
  initial begin
    repeat (5) @(posedge CLOCK);
    RST <= 1'b0;
    @(posedge CLOCK);
    chk("div_rst", 32'h0000_0000, {dh, dl});
    chk("flags_rst", 32'h0000_0000, {en, wk, ov, irq, hold});
    axr(4'h8, d, r);
    chk("bitcyc_rst", 32'h0000_0010, d);
    axr(4'h4, d, r);
    chk("data_rst", 32'h0000_0055, d);
    axr(4'hC, d, r);
    chk("unmapped_rd", 32'h0000_0002, {d[29:0], r});
    axw(4'hC, 32'h0000_0001, r);
    chk("unmapped_wr", 32'h0000_0002, r);
    $display("register test done");
    dwd <= 16'(rnd());
    pulse(5);
    chk("div_write", dwd, {dh, dl});
    v = {dh, dl};
    pulse(0);
    dwd <= 16'(rnd());
    pulse(5);
    chk("div_locked", v, {dh, dl});
    pulse(1);
    pulse(3);
    chk("abort", 32'h0000_0000, {en, hold, ov, irq});
    $display("abort test done");
    for (int s = 0; s < 4; s++) calib(2'(s), 1'b0);
    calib(2'h3, 1'b1);
    calib(2'(rnd()), 1'b1);
    summarize();
  end
endmodule // tb
